// File: hdl/bcc_clkgen.sv
// Purpose: Five phased switching clocks following the sync input
// Assumes: sync_clock_in asynchronous to sys_clk
// Notes:   Period measured in sys_clk cycles; changes only at period wrap
`timescale 1ns/1ps
module bcc_clkgen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sync pin
  input wire logic sync_clock_in,
  // Phased clocks and status
  output logic [bcc_pkg::NCONV-1:0] ph_clk,
  output logic sync_locked
);
  import bcc_pkg::*;

  logic sync_m, sync_s, sync_d;
  logic [PW-1:0] meas_r, per_meas_r, per_r, ph_cnt_r, tgt;
  logic lock_r, rise;
  logic [NCONV-1:0] ph_r;

  // ==========================================================================
  // Input synchroniser and edge detect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_m <= 1'b0;
      sync_s <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      sync_m <= sync_clock_in;
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end
  assign rise = sync_s & ~sync_d;

  // Clamp a measured period into the saturation window
  function automatic logic [PW-1:0] clamp(logic [PW-1:0] p);
    if (p < PER_MIN) return PER_MIN;
    if (p > PER_MAX) return PER_MAX;
    return p;
  endfunction

  // ==========================================================================
  // Period measurement and loss detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meas_r <= PER_LOSS;
      per_meas_r <= PER_FALLBACK;
      lock_r <= 1'b0;
    end else if (rise) begin
      meas_r <= PW'(1);
      if (meas_r < PER_LOSS) begin
        per_meas_r <= clamp(meas_r);
        lock_r <= 1'b1;
      end
    end else if (meas_r < PER_LOSS) begin
      meas_r <= meas_r + PW'(1);
    end else begin
      lock_r <= 1'b0;
    end
  end
  assign tgt = lock_r ? per_meas_r : PER_FALLBACK;

  // ==========================================================================
  // Phase counter, period taken only at wrap so no runt edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_r <= PER_FALLBACK;
      ph_cnt_r <= '0;
    end else if (ph_cnt_r >= per_r - PW'(1)) begin
      ph_cnt_r <= '0;
      per_r <= tgt;
    end else begin
      ph_cnt_r <= ph_cnt_r + PW'(1);
    end
  end

  // Five clocks, each offset by a fifth of the period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_r <= '0;
    end else begin
      for (int i = 0; i < NCONV; i++) begin
        logic [PW-1:0] off, pos;
        off = PW'((32'(per_r) * i) / NCONV);
        pos = (ph_cnt_r >= off) ? ph_cnt_r - off : ph_cnt_r + per_r - off;
        ph_r[i] <= pos < (per_r >> 1);
      end
    end
  end
  assign ph_clk = ph_r;
  assign sync_locked = lock_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_period_clamp: assert property (per_r >= PER_MIN && per_r <= PER_MAX)
    else $error("period outside saturation window");
  chk_loss_fallback: assert property ((meas_r == PER_LOSS && !rise) |=> !lock_r)
    else $error("lock kept after sync loss");
  chk_period_wrap: assert property ($changed(per_r) |-> $past(ph_cnt_r) == $past(per_r) - 1)
    else $error("period changed mid cycle");
  chk_phase_count: assert property (ph_cnt_r < per_r)
    else $error("phase counter overran period");
endmodule

// File: hdl/bcc_ctrl.sv
// Purpose: Control logic for five step-down converters, one pair combinable
// Assumes: Sequencer inputs and straps on sys_clk; pins asynchronous
// Notes:   Registers over classic Wishbone, registered ack
// Summary of operation
// - Low-quiescent, level above 2.8 V, low supply: off
// - Discharge bit pulls output only while disabled
// - Current monitor routes at most one source
// - Enable by sequence slot, pin or register
// - Default level and start enable from OTP
// - Nonzero level changes while on only accepted in forced PWM
// - Level select zero disables the converter
// - Range bit frozen while converter is active
// - Active-state mode field picks eco, PWM, off
// - Sleep mode field applied per pin assignment
// - Pulldown default on, both nodes, master only
// - Warm reset reloads or keeps per converter
// - PWM uses sync clock, eco uses RC
// - Five phased switching clocks from sync
// - No sync gives 2.2 MHz fallback
// - Sync tracked, clamped to 1.7-2.7 MHz
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
module bcc_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic sync_clock_in,
  input wire logic sleep_request_pin_n,
  input wire logic enable_pin_one,
  input wire logic enable_pin_two,
  input wire logic vin_low,
  input wire logic rc_osc_clk,
  // Sequencer and straps
  input wire logic dev_sleep,
  input wire logic [bcc_pkg::NCONV-1:0] seq_slot_en,
  input wire logic warm_reset,
  input wire logic [bcc_pkg::NCONV*bcc_pkg::LW-1:0] otp_level,
  input wire logic [bcc_pkg::NCONV-1:0] otp_range,
  input wire logic [bcc_pkg::NCONV-1:0] otp_start_en,
  input wire logic otp_dual_phase,
  // Converter drive
  output logic [bcc_pkg::NCONV-1:0] conv_on,
  output logic [bcc_pkg::NCONV-1:0] conv_pwm,
  output logic [bcc_pkg::NCONV-1:0] conv_clk,
  output logic [bcc_pkg::NCONV*bcc_pkg::LW-1:0] conv_level,
  output logic [bcc_pkg::NCONV-1:0] conv_range,
  output logic [bcc_pkg::NCONV-1:0] discharge_en,
  output logic [bcc_pkg::NCONV-1:0] pd_sw_en,
  output logic [bcc_pkg::NCONV-1:0] pd_fb_en,
  // Current monitor routing
  output logic [bcc_pkg::NCONV-1:0] imon_route,
  output logic imon_pair
);
  import bcc_pkg::*;

  // ==========================================================================
  // Declarations
  logic [4:0] pin_m, pin_s;
  logic slp_req, e1, e2, vin_lo, rc_s;
  logic ack_r, wr_fire;
  logic [31:0] rdat_r, rd_cur, wmrg;
  logic [1:0] mact_r [NCONV];
  logic [1:0] mslp_r [NCONV];
  logic [1:0] md_eff [NCONV];
  logic [LW-1:0] sel_r [NCONV];
  logic [NCONV-1:0] disch_r, wkeep_r, ren_r, range_r, pd_r;
  logic [NCONV-1:0] as_slp_r, as_e1_r, as_e2_r, cut_r, cut_set, on_nxt;
  logic [NCONV-1:0] ctl_wr, lvl_wr;
  logic [2:0] imon_r;
  logic load_r, dual, sync_locked;
  logic [NCONV-1:0] on_r, pwm_r, clk_r, range_o_r, disch_o_r, pdsw_r, pdfb_r;
  logic [NCONV-1:0] imon_route_r;
  logic imon_pair_r;
  logic [NCONV*LW-1:0] level_o_r;
  logic [NCONV-1:0] ph_clk;

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_m <= 5'h01;
      pin_s <= 5'h01;
    end else begin
      pin_m <= {rc_osc_clk, vin_low, enable_pin_two, enable_pin_one, sleep_request_pin_n};
      pin_s <= pin_m;
    end
  end
  assign slp_req = ~pin_s[0];
  assign e1 = pin_s[1];
  assign e2 = pin_s[2];
  assign vin_lo = pin_s[3];
  assign rc_s = pin_s[4];
  assign dual = otp_dual_phase;

  // ==========================================================================
  // Wishbone slave: ack one cycle after request, write at ack edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (!ack_r) rdat_r <= rd_cur;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

  // Byte-lane merge of write data over current contents
  function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  // Write strobes per converter
  always_comb begin
    for (int i = 0; i < NCONV; i++) begin
      ctl_wr[i] = wr_fire && wb_adr_i == reg_addr(A_CTRL0, i);
      lvl_wr[i] = wr_fire && wb_adr_i == reg_addr(A_LVL0, i);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_cur = '0;
    for (int i = 0; i < NCONV; i++) begin
      if (wb_adr_i == reg_addr(A_CTRL0, i))
        rd_cur = {21'h0, md_eff[i], on_r[i], 1'b0, ren_r[i], wkeep_r[i], disch_r[i],
                  mslp_r[i], mact_r[i]};
      if (wb_adr_i == reg_addr(A_LVL0, i))
        rd_cur = {24'h0, range_r[i], sel_r[i]};
    end
    case (wb_adr_i)
      A_PD: rd_cur = {27'h0, pd_r};
      A_IMON: rd_cur = {29'h0, imon_r};
      A_ASSIGN: rd_cur = {11'h0, as_e2_r, 3'h0, as_e1_r, 3'h0, as_slp_r};
      A_STAT: rd_cur = {15'h0, sync_locked, 3'h0, cut_r, 3'h0, on_r};
      default: ;
    endcase
  end
  assign wmrg = wmerge(rd_cur, wb_dat_i, wb_sel_i);

  // ==========================================================================
  // Converter control registers, mode fields survive warm reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCONV; i++) begin
        mact_r[i] <= MACT_RST;
        mslp_r[i] <= MSLP_RST;
      end
      disch_r <= DISCH_RST;
      wkeep_r <= '0;
    end else begin
      for (int i = 0; i < NCONV; i++) begin
        if (ctl_wr[i]) begin
          mact_r[i] <= wmrg[F_MACT +: 2];
          mslp_r[i] <= wmrg[F_MSLP +: 2];
          disch_r[i] <= wmrg[F_DISCH];
          wkeep_r[i] <= wmrg[F_WKEEP];
        end
      end
    end
  end

  // ==========================================================================
  // OTP-backed state: level, range, register enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCONV; i++) sel_r[i] <= '0;
      range_r <= '0;
      ren_r <= '0;
      load_r <= 1'b1;
    end else if (load_r) begin
      for (int i = 0; i < NCONV; i++) sel_r[i] <= otp_level[i*LW +: LW];
      range_r <= otp_range;
      ren_r <= otp_start_en;
      load_r <= 1'b0;
    end else begin
      for (int i = 0; i < NCONV; i++) begin
        if (warm_reset && !wkeep_r[i]) begin
          sel_r[i] <= otp_level[i*LW +: LW];
          range_r[i] <= otp_range[i];
          ren_r[i] <= otp_start_en[i];
        end else begin
          if (ctl_wr[i]) ren_r[i] <= wmrg[F_REN];
          if (lvl_wr[i]) begin
            if (wmrg[F_SEL +: LW] == '0) begin
              sel_r[i] <= '0;
            end else if (!on_r[i] ||
                         (md_eff[i] == BCC_PWM && wmrg[F_RANGE] == range_r[i])) begin
              sel_r[i] <= wmrg[F_SEL +: LW];
              range_r[i] <= wmrg[F_RANGE];
            end
          end
        end
      end
    end
  end

  // ==========================================================================
  // Pulldown, monitor select and pin assignment registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pd_r <= PD_RST;
      imon_r <= BCC_IM_NONE;
      as_slp_r <= '0;
      as_e1_r <= '0;
      as_e2_r <= '0;
    end else if (wr_fire) begin
      case (wb_adr_i)
        A_PD: pd_r <= wmrg[NCONV-1:0];
        A_IMON: imon_r <= wmrg[F_IMON +: 3];
        A_ASSIGN: begin
          as_slp_r <= wmrg[F_AS_SLP +: NCONV];
          as_e1_r <= wmrg[F_AS_E1 +: NCONV];
          as_e2_r <= wmrg[F_AS_E2 +: NCONV];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Effective mode and enable; converter two follows one when paired
  always_comb begin
    int j;
    logic hold, asg;
    j = 0;
    hold = 1'b0;
    asg = 1'b0;
    for (int i = 0; i < NCONV; i++) begin
      j = (dual && i == 1) ? 0 : i;
      hold = (as_slp_r[j] & slp_req) | (as_e1_r[j] & e1) | (as_e2_r[j] & e2);
      asg = as_slp_r[j] | as_e1_r[j] | as_e2_r[j];
      md_eff[i] = (dev_sleep && asg && !hold) ? mslp_r[j] : mact_r[j];
      cut_set[i] = md_eff[i] == BCC_ECO && lvl_high(range_r[j], sel_r[j]) && vin_lo;
      on_nxt[i] = (seq_slot_en[j] | ren_r[j] | (asg & hold))
                  && sel_r[j] != '0
                  && (md_eff[i] == BCC_ECO || md_eff[i] == BCC_PWM)
                  && !cut_r[i] && !cut_set[i];
    end
  end

  // Supply cut-off latch, held until the converter leaves eco
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cut_r <= '0;
    else begin
      for (int i = 0; i < NCONV; i++)
        cut_r[i] <= cut_set[i] | (cut_r[i] & md_eff[i] == BCC_ECO);
    end
  end

  // ==========================================================================
  // Registered converter drive
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_r <= '0;
      pwm_r <= '0;
      clk_r <= '0;
      level_o_r <= '0;
      range_o_r <= '0;
      disch_o_r <= '0;
      pdsw_r <= '0;
      pdfb_r <= '0;
    end else begin
      for (int i = 0; i < NCONV; i++) begin
        int j;
        j = (dual && i == 1) ? 0 : i;
        on_r[i] <= on_nxt[i];
        pwm_r[i] <= on_nxt[i] && md_eff[i] == BCC_PWM;
        clk_r[i] <= (md_eff[i] == BCC_PWM) ? ph_clk[i] : rc_s;
        level_o_r[i*LW +: LW] <= sel_r[j];
        range_o_r[i] <= range_r[j];
        disch_o_r[i] <= disch_r[j] & ~on_nxt[i];
        pdsw_r[i] <= pd_r[i] & ~on_nxt[i] & ~(dual && i == 1);
        pdfb_r[i] <= pd_r[i] & ~on_nxt[i] & ~(dual && i == 1);
      end
    end
  end

  // Current monitor routing, one-hot
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      imon_route_r <= '0;
      imon_pair_r <= 1'b0;
    end else begin
      imon_route_r <= '0;
      imon_pair_r <= 1'b0;
      case (imon_r)
        BCC_IM_ONE: imon_route_r[0] <= 1'b1;
        BCC_IM_TWO: imon_route_r[1] <= 1'b1;
        BCC_IM_PAIR: begin
          imon_route_r[0] <= 1'b1;
          imon_pair_r <= 1'b1;
        end
        BCC_IM_THREE: imon_route_r[2] <= 1'b1;
        BCC_IM_FIVE: imon_route_r[4] <= 1'b1;
        default: ;
      endcase
    end
  end

  assign conv_on = on_r;
  assign conv_pwm = pwm_r;
  assign conv_clk = clk_r;
  assign conv_level = level_o_r;
  assign conv_range = range_o_r;
  assign discharge_en = disch_o_r;
  assign pd_sw_en = pdsw_r;
  assign pd_fb_en = pdfb_r;
  assign imon_route = imon_route_r;
  assign imon_pair = imon_pair_r;

  // ==========================================================================
  // Phased clock generator
  bcc_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .rst(rst),
    .sync_clock_in(sync_clock_in),
    .ph_clk(ph_clk),
    .sync_locked(sync_locked)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_zero_then_off(int k);
    (sel_r[k] == '0) ##1 !on_r[k];
  endsequence

  for (genvar g = 0; g < NCONV; g++) begin : g_chk
    chk_eco_cutoff: assert property (cut_set[g] |=> !on_r[g] ##1 !on_r[g])
      else $error("converter stayed on after supply cut-off");
    chk_discharge_off: assert property (on_r[g] |-> !disch_o_r[g])
      else $error("discharge active while converter on");
    chk_zero_disable: assert property (
        (lvl_wr[g] && !warm_reset && !(dual && g == 1) && wmrg[F_SEL +: LW] == '0)
        |=> s_zero_then_off(g))
      else $error("zero level did not disable converter");
    chk_eco_level_hold: assert property (
        (lvl_wr[g] && !warm_reset && on_r[g] && md_eff[g] == BCC_ECO
         && wmrg[F_SEL +: LW] != '0) |=> $stable(sel_r[g]))
      else $error("level changed in low-quiescent mode");
    chk_range_frozen: assert property (
        ($changed(range_r[g]) && !$past(warm_reset) && !$past(load_r))
        |-> !$past(on_r[g]))
      else $error("range changed while converter active");
  end

  chk_imon_onehot: assert property ($onehot0(imon_route_r) && (!imon_pair_r || imon_route_r[0]))
    else $error("current monitor routes more than one source");
  chk_pd_master: assert property (dual |=> !pdsw_r[1] && !pdfb_r[1] && pdsw_r == pdfb_r)
    else $error("pulldown on slave phase or nodes split");
endmodule

// File: include/bcc_pkg.sv
// Purpose: Shared constants and types for the buck converter control block
// Assumes: 32-bit classic Wishbone, byte addresses, one aligned word per register
// Notes:   Converter index 0..4 maps to converters one..five
package bcc_pkg;
  // ==========================================================================
  // Sizes
  localparam int NCONV = 5;
  localparam int LW = 7;
  localparam int PW = 8;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_LVL0 = 8'h20;
  localparam logic [7:0] A_PD = 8'h40;
  localparam logic [7:0] A_IMON = 8'h44;
  localparam logic [7:0] A_ASSIGN = 8'h48;
  localparam logic [7:0] A_STAT = 8'h4c;
  localparam logic [7:0] A_STRIDE = 8'h04;
  // Field positions
  localparam int F_MACT = 0;
  localparam int F_MSLP = 2;
  localparam int F_DISCH = 4;
  localparam int F_WKEEP = 5;
  localparam int F_REN = 6;
  localparam int F_SEL = 0;
  localparam int F_RANGE = 7;
  localparam int F_AS_SLP = 0;
  localparam int F_AS_E1 = 8;
  localparam int F_AS_E2 = 16;
  localparam int F_IMON = 0;
  // ==========================================================================
  // Modes, Gray along off -> low-quiescent -> forced PWM
  typedef enum logic [1:0] {
    BCC_OFF = 2'h0,
    BCC_ECO = 2'h1,
    BCC_PWM = 2'h3
  } bcc_mode_t;
  // Current monitor source codes
  typedef enum logic [2:0] {
    BCC_IM_NONE = 3'h0,
    BCC_IM_ONE = 3'h1,
    BCC_IM_TWO = 3'h2,
    BCC_IM_PAIR = 3'h3,
    BCC_IM_THREE = 3'h4,
    BCC_IM_FIVE = 3'h5
  } bcc_imon_t;
  // ==========================================================================
  // Reset values
  localparam logic [1:0] MACT_RST = 2'h3;
  localparam logic [1:0] MSLP_RST = 2'h0;
  localparam logic [NCONV-1:0] DISCH_RST = 5'h1f;
  localparam logic [NCONV-1:0] PD_RST = 5'h1f;
  // ==========================================================================
  // Level scale
  localparam int R0_BASE_MV = 700;
  localparam int R0_STEP_MV = 10;
  localparam int R1_BASE_MV = 1000;
  localparam int R1_STEP_MV = 20;
  localparam int ECO_LIMIT_MV = 2800;
  // ==========================================================================
  // Clock generation
  localparam int SYS_HZ = 125_000_000;
  localparam int FALLBACK_HZ = 2_200_000;
  localparam int SAT_LO_HZ = 1_700_000;
  localparam int SAT_HI_HZ = 2_700_000;
  localparam logic [PW-1:0] PER_FALLBACK = PW'(SYS_HZ / FALLBACK_HZ);
  localparam logic [PW-1:0] PER_MIN = PW'(SYS_HZ / SAT_HI_HZ);
  localparam logic [PW-1:0] PER_MAX = PW'((SYS_HZ + SAT_LO_HZ - 1) / SAT_LO_HZ);
  localparam logic [PW-1:0] PER_LOSS = PW'(2 * ((SYS_HZ + SAT_LO_HZ - 1) / SAT_LO_HZ));

  // Programmed level above the low-quiescent supply limit
  function automatic logic lvl_high(logic rng, logic [LW-1:0] sel);
    int mv;
    mv = rng ? R1_BASE_MV + R1_STEP_MV * (int'(sel) - 1)
             : R0_BASE_MV + R0_STEP_MV * (int'(sel) - 1);
    return (sel != '0) && (mv > ECO_LIMIT_MV);
  endfunction

  // Byte address of entry i of a bank
  function automatic logic [7:0] reg_addr(logic [7:0] base, int i);
    return 8'(int'(base) + int'(A_STRIDE) * i);
  endfunction
endpackage

// File: sim/bcc_ctrl_bench.sv
// Purpose: Self-checking bench for the buck converter control block
// Assumes: Host on classic Wishbone, sync source model on the sync pin
// Notes:   Periods counted in sys_clk cycles at 125 MHz
`timescale 1ns/1ps
module bcc_ctrl_bench;
  import bcc_pkg::*;
  // ==========================================================
  // Signals
  logic sys_clk, rst, cyc, stb, we, en1, en2, nslp_n, vlow, rc, slp, wrst, ack, sync, imp;
  logic dph;
  logic [7:0] adr, p;
  logic [31:0] wdat, rdat, q;
  logic [15:0] half_ns;
  logic [NCONV-1:0] slot, on, pwm, cclk, dis, pdsw, pdfb, imr, rng;
  logic [NCONV*LW-1:0] lvl;
  int n_fail, num_checks;
  logic [5:0] imx [1:5] = '{6'h01, 6'h02, 6'h21, 6'h04, 6'h10};
  logic [15:0] hx [5] = '{16'h0, 16'hc8, 16'ha0, 16'h190, 16'h0};
  logic [7:0] px [5] = '{PER_FALLBACK, 8'h32, PER_MIN, PER_MAX, PER_FALLBACK};
  // ==========================================================
  // Design and sync source
  bcc_ctrl uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sync_clock_in(sync), .sleep_request_pin_n(nslp_n),
    .enable_pin_one(en1), .enable_pin_two(en2), .vin_low(vlow), .rc_osc_clk(rc),
    .dev_sleep(slp), .seq_slot_en(slot), .warm_reset(wrst), .otp_level({5{7'h10}}),
    .otp_range(5'h0), .otp_start_en(5'h03), .otp_dual_phase(dph), .conv_on(on),
    .conv_pwm(pwm), .conv_clk(cclk), .conv_level(lvl), .conv_range(rng),
    .discharge_en(dis), .pd_sw_en(pdsw), .pd_fb_en(pdfb), .imon_route(imr),
    .imon_pair(imp));
  bcc_sync_src src (.half_ns(half_ns), .sync_clock_in(sync));
  // ==========================================================
  // Clocks
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Slow stand-in for the RC oscillator
  initial begin
    rc = 1'b0;
    forever #151 rc = ~rc;
  end
  // ==========================================================
  // Tasks
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  // One classic Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      close_out();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Wait some cycles
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Cycles between two rising edges of phase clock zero
  task automatic per;
    int n, e;
    logic pv;
    e = 0;
    p = 8'h0;
    pv = 1'b1;
    for (n = 0; n < 400 && e < 2; n++) begin
      @(posedge sys_clk);
      if (e == 1) p = p + 8'h1;
      if (cclk[0] === 1'b1 && pv === 1'b0) e++;
      pv = cclk[0];
    end
    if (e < 2) begin
      n_fail++;
      close_out();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst, cyc, stb, we, en1, en2, vlow, slp, wrst} = 9'h100;
    nslp_n = 1'b1;
    dph = 1'b0;
    adr = 8'h0;
    wdat = 32'h0;
    slot = 5'h0;
    half_ns = 16'h0;
    n_fail = 0;
    num_checks = 0;
    wt(16);
    rst <= 1'b0;
    wt(4);
    wb(0, A_CTRL0, 0); chk("ctrl0", q & 32'h3f, 32'h13);
    wb(0, A_PD, 0); chk("pd", q, 32'h1f);
    chk("pd sw", 32'(pdsw), 32'h1c);
    chk("pd fb", 32'(pdfb), 32'h1c);
    chk("on", 32'(on), 32'h03);
    chk("pwm", 32'(pwm), 32'h03);
    chk("rng", 32'(rng), 32'h0);
    chk("lvl", 32'(lvl[6:0]), 32'h10);
    chk("dis", 32'(dis), 32'h1c);
    for (int i = 1; i <= 5; i++) begin
      wb(1, A_IMON, i); wt(3); chk("imon", 32'({imp, imr}), 32'(imx[i]));
    end
    slot <= 5'h10; wt(4); chk("slot", 32'({on[4], dis[4]}), 32'h2);
    wb(1, A_ASSIGN, 32'h400); en1 <= 1'b1; wt(6); chk("pin", 32'(on[2]), 32'h1);
    en1 <= 1'b0; wt(6); chk("pin off", 32'(on[2]), 32'h0);
    wb(1, A_LVL0, 32'h20); wb(0, A_LVL0, 0); chk("pwm lvl", q, 32'h20);
    wrst <= 1'b1; wt(1); wrst <= 1'b0; wt(3);
    wb(0, A_LVL0, 0); chk("warm", q, 32'h10);
    wb(1, A_CTRL0, 32'h73); wb(1, A_LVL0, 32'h20); wrst <= 1'b1; wt(1); wrst <= 1'b0; wt(3);
    wb(0, A_LVL0, 0); chk("keep", q, 32'h20);
    wb(1, A_LVL0, 32'ha0); wb(0, A_LVL0, 0); chk("range", q, 32'h20);
    chk("rng", 32'(rng[0]), 32'h0);
    wb(1, A_CTRL0, 32'h51); wb(1, A_LVL0, 32'h30); wb(0, A_LVL0, 0);
    chk("eco lvl", q, 32'h20);
    chk("eco pwm", 32'(pwm[0]), 32'h0);
    wb(1, A_CTRL0, 32'h53); wb(1, A_LVL0, 0); wt(3); chk("sel0", 32'(on[0]), 32'h0);
    wb(1, A_LVL0, 32'he4); wb(1, A_CTRL0, 32'h51); vlow <= 1'b1; wt(6);
    chk("cut", 32'(on[0]), 32'h0);
    vlow <= 1'b0; wb(1, A_CTRL0, 32'h53); wb(1, A_LVL0, 32'h10);
    wb(1, A_ASSIGN, 32'h100000); slp <= 1'b1; wt(6); chk("slp off", 32'(on[4]), 32'h0);
    en2 <= 1'b1; wt(6); chk("slp pin", 32'(on[4]), 32'h1); en2 <= 1'b0;
    wb(1, reg_addr(A_CTRL0, 4), 32'h1f); wt(4); chk("slp pwm", 32'(on[4]), 32'h1);
    slp <= 1'b0;
    wb(0, 8'h80, 0); chk("unmapped", q, 32'h0);
    for (int i = 0; i < 5; i++) begin
      half_ns <= hx[i]; wt(800); per(); chk("period", 32'(p), 32'(px[i]));
    end
    // Paired converters: slave phase pulldowns stay off
    dph <= 1'b1; wb(1, A_LVL0, 0); wt(4);
    chk("pd pair", 32'({pdfb[1:0], pdsw[1:0]}), 32'h5);
    close_out();
  end
endmodule

// File: sim/bcc_sync_src.sv
// Purpose: External sync clock source for the converter clock generator
// Assumes: Half period in ns set by the bench, zero means no clock
// Notes:   Pin rests low while the source is stopped
`timescale 1ns/1ps
module bcc_sync_src (
  // Rate control
  input wire logic [15:0] half_ns,
  // Sync pin
  output logic sync_clock_in
);
  // ==========================================================
  // Clock source
  // Toggle at the requested rate, rest low when stopped
  initial begin
    sync_clock_in = 1'b0;
    forever begin
      if (half_ns == 16'h0) begin
        sync_clock_in = 1'b0;
        #8;
      end else begin
        #(half_ns) sync_clock_in = ~sync_clock_in;
      end
    end
  end
endmodule
